/* File: hdl/ctm_transceiver.sv */
// transceiver end: mode select, bus mapping, wake indication, timeout
`timescale 1ns/1ps
`include "ctm_cfg.svh"
module ctm_transceiver
#(
    parameter int DTO_CYC = `CTM_DTO_CYC
)
(
    // clock, reset, enable
    input  wire logic  ref_clk,
    input  wire logic  arst_n,
    input  wire logic  ce,
    // pins toward the controller
    ctm_if.dev         pins,
    // bus side, asynchronous to ref_clk
    input  wire logic  busDomIn,
    input  wire logic  wakePatternIn,
    input  wire logic  logicIoSupplyIn,
    // bus drive and status
    output logic       busDriveDom,
    output logic       busWeakGnd,
    output logic       dominantTimeout,
    output logic [1:0] modeOut
);

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    localparam int W = `CTM_DTO_CNT_W;
    localparam logic [W-1:0] DTO_LIM = W'(DTO_CYC - 1);

    ctm_pkg::ctm_mode_e mode;
    ctm_pkg::ctm_mode_e next_mode;
    logic [1:0]         busSync;
    logic [1:0]         wakeSync;
    logic [1:0]         supSync;
    logic               txdPrev;
    logic               armed;
    logic [W-1:0]       domCnt;
    logic               wakeFlag;
    logic               busDom;

    // ------------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------------
    // off-chip levels pass two flops before use
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busSync  <= 2'h0;
            wakeSync <= 2'h0;
            supSync  <= 2'h0;
        end
        else if (ce)
        begin
            busSync  <= {busSync[0], busDomIn};
            wakeSync <= {wakeSync[0], wakePatternIn};
            supSync  <= {supSync[0], logicIoSupplyIn};
        end
    end

    // ------------------------------------------------------------------------
    // mode selection
    // ------------------------------------------------------------------------
    // pin biases are resolved in the interface: floating standby reads
    // high, floating shutdown reads low
    always_comb
    begin
        next_mode = ctm_pkg::ctm_decode_mode(pins.stbLevel,
                                             pins.shdnLevel);
    end

    // reset into standby, the low current default of a floating pin
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            mode <= ctm_pkg::MODE_STANDBY;
        else if (ce)
            mode <= next_mode;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            modeOut <= 2'h1;
        else if (ce)
            modeOut <= next_mode;
    end

    // ------------------------------------------------------------------------
    // dominant timeout
    // ------------------------------------------------------------------------
    // armed by a falling transmit edge only; a level held low from before
    // normal mode does not start the count
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            txdPrev <= 1'b1;
            armed   <= 1'b0;
            domCnt  <= '0;
        end
        else if (ce)
        begin
            txdPrev <= pins.txdLevel;
            if (pins.txdLevel || mode != ctm_pkg::MODE_NORMAL)
            begin
                armed  <= 1'b0;
                domCnt <= '0;
            end
            else if (txdPrev)
            begin
                armed  <= 1'b1;
                domCnt <= '0;
            end
            else if (armed && domCnt != DTO_LIM)
                domCnt <= domCnt + 1'b1;
        end
    end

    // fault latches on expiry, clears once transmit is recessive
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            dominantTimeout <= 1'b0;
        else if (ce)
        begin
            if (pins.txdLevel || mode != ctm_pkg::MODE_NORMAL)
                dominantTimeout <= 1'b0;
            else if (armed && domCnt == DTO_LIM)
                dominantTimeout <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // bus driver
    // ------------------------------------------------------------------------
    // the fault flop is one cycle late, so the expiry term is also gated
    // here to cut the driver in the same cycle as the fault sets
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busDriveDom <= 1'b0;
            busWeakGnd  <= 1'b1;
        end
        else if (ce)
        begin
            busDriveDom <= next_mode == ctm_pkg::MODE_NORMAL
                           && mode == ctm_pkg::MODE_NORMAL
                           && !pins.txdLevel
                           && !dominantTimeout
                           && !(armed && domCnt == DTO_LIM);
            busWeakGnd  <= next_mode != ctm_pkg::MODE_NORMAL;
        end
    end

    // ------------------------------------------------------------------------
    // wake indication
    // ------------------------------------------------------------------------
    // wake receiver is live in standby only; shutdown kills it; the flag
    // is held until the host leaves standby
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            wakeFlag <= 1'b0;
        else if (ce)
        begin
            if (mode != ctm_pkg::MODE_STANDBY)
                wakeFlag <= 1'b0;
            else if (wakeSync[1])
                wakeFlag <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // receive pin
    // ------------------------------------------------------------------------
    // wired bus: own drive or any other node makes it dominant
    assign busDom = busSync[1] || busDriveDom;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pins.rxdOut <= `CTM_RXD_RST;
            pins.rxdOe  <= 1'b0;
        end
        else if (ce)
        begin
            pins.rxdOe <= supSync[1];
            case (mode)
                ctm_pkg::MODE_NORMAL:
                    pins.rxdOut <= !busDom;
                ctm_pkg::MODE_STANDBY:
                    pins.rxdOut <= !wakeFlag;
                ctm_pkg::MODE_SHUTDOWN:
                    pins.rxdOut <= 1'b1;
                default:
                    pins.rxdOut <= 1'b1;
            endcase
        end
    end

endmodule : ctm_transceiver

/* File: common/ctm_cfg.svh */
// timing counts and reset values for the transceiver mode and timeout logic
`ifndef CTM_CFG_SVH
`define CTM_CFG_SVH

// ----------------------------------------------------------------------------
// clock and dominant timeout
// ----------------------------------------------------------------------------
`define CTM_CLK_KHZ          10000
`define CTM_DTO_PERIOD_US    1200
`define CTM_DTO_CYC          ((`CTM_DTO_PERIOD_US * `CTM_CLK_KHZ) / 1000)
`define CTM_DTO_CNT_W        14
`define CTM_MAX_DOM_BITS     11
// shortened timeout so the bench run stays brief
`define CTM_SIM_DTO_CYC      20

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CTM_RXD_RST          1'b1
`define CTM_TXD_RST          1'b1
`define CTM_STB_RST          1'b1
`define CTM_SHUTDOWN_SELECT_RST         1'b0

`endif

/* File: common/ctm_pkg.sv */
// types and mode decode shared by both ends
package ctm_pkg;

    // ------------------------------------------------------------------------
    // operating modes
    // ------------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        MODE_NORMAL,
        MODE_STANDBY,
        MODE_SHUTDOWN
    } ctm_mode_e;

    // shutdown beats standby; standby high selects low current mode
    function automatic ctm_mode_e ctm_decode_mode(input logic stbLevel,
                                                  input logic shdnLevel);
        ctm_mode_e m;
        m = MODE_NORMAL;
        if (shdnLevel)
            m = MODE_SHUTDOWN;
        else if (stbLevel)
            m = MODE_STANDBY;
        return m;
    endfunction : ctm_decode_mode

endpackage : ctm_pkg

/* File: common/ctm_if.sv */
// logic-side pins between protocol controller and transceiver
`timescale 1ns/1ps
interface ctm_if;

    // ------------------------------------------------------------------------
    // driven by each end, with enables
    // ------------------------------------------------------------------------
    logic txdOut;
    logic txdOe;
    logic stbOut;
    logic stbOe;
    logic shdnOut;
    logic shdnOe;
    logic rxdOut;
    logic rxdOe;

    // ------------------------------------------------------------------------
    // resolved pin levels, internal biases when nobody drives
    // ------------------------------------------------------------------------
    logic txdLevel;
    logic stbLevel;
    logic shdnLevel;
    logic rxdLevel;

    assign txdLevel  = txdOe  ? txdOut  : 1'b1;   // pull-up
    assign stbLevel  = stbOe  ? stbOut  : 1'b1;   // pull-up
    assign shdnLevel = shdnOe ? shdnOut : 1'b0;   // pull-down
    assign rxdLevel  = rxdOe  ? rxdOut  : 1'b1;   // undriven reads high

    modport dev
    (
        input  txdLevel,
        input  stbLevel,
        input  shdnLevel,
        output rxdOut,
        output rxdOe
    );

    modport host
    (
        output txdOut,
        output txdOe,
        output stbOut,
        output stbOe,
        output shdnOut,
        output shdnOe,
        input  rxdLevel
    );

endinterface : ctm_if

/* File: hdl/ctm_controller.sv */
// controller end: drives mode and transmit pins, watches receive pin
`timescale 1ns/1ps
`include "ctm_cfg.svh"
module ctm_controller
(
    // clock, reset, enable
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    // pins toward the transceiver
    ctm_if.host              pins,
    // user side
    input  wire logic        tieNormal,
    input  wire logic        reqStandby,
    input  wire logic        reqShutdown,
    input  wire logic        autoWake,
    input  wire logic        txBit,
    input  wire logic [15:0] bitPeriod,
    output logic             rxBit,
    output logic             wakeSeen,
    output logic             rateOk
);

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    ctm_pkg::ctm_mode_e     mode;
    logic                   wakeHold;
    logic [23:0]            domRun;
    localparam logic [23:0] DTO_CYC24 = 24'(`CTM_DTO_CYC);
    localparam logic [7:0]  MAX_BITS  = 8'(`CTM_MAX_DOM_BITS);

    assign domRun = 24'(bitPeriod) * 24'(MAX_BITS);

    // wake latch: set wins over release of standby
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            wakeHold <= 1'b0;
        else if (ce)
        begin
            if (mode == ctm_pkg::MODE_STANDBY && !pins.rxdLevel)
                wakeHold <= 1'b1;
            else if (!reqStandby)
                wakeHold <= 1'b0;
        end
    end

    // mode pins; a wake in standby returns to normal when allowed
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pins.stbOut  <= `CTM_STB_RST;
            pins.stbOe   <= 1'b0;
            pins.shdnOut <= `CTM_SHUTDOWN_SELECT_RST;
            pins.shdnOe  <= 1'b0;
            mode         <= ctm_pkg::MODE_STANDBY;
        end
        else if (ce)
        begin
            pins.stbOe   <= 1'b1;
            pins.shdnOe  <= 1'b1;
            pins.shdnOut <= reqShutdown;
            // permanent ground when only normal mode is used
            pins.stbOut  <= !tieNormal && reqStandby
                            && !(autoWake && wakeHold);
            mode         <= ctm_pkg::ctm_decode_mode(pins.stbOut,
                                                     pins.shdnOut);
        end
    end

    // transmit and receive levels: low is dominant
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pins.txdOut <= `CTM_TXD_RST;
            pins.txdOe  <= 1'b0;
            rxBit       <= `CTM_RXD_RST;
            wakeSeen    <= 1'b0;
        end
        else if (ce)
        begin
            pins.txdOe  <= 1'b1;
            pins.txdOut <= txBit;
            rxBit       <= pins.rxdLevel;
            wakeSeen    <= mode == ctm_pkg::MODE_STANDBY
                           && !pins.rxdLevel;
        end
    end

    // eleven dominant bits must end inside the timeout
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            rateOk <= 1'b0;
        else if (ce)
            rateOk <= bitPeriod != 16'h0000 && domRun < DTO_CYC24;
    end

endmodule : ctm_controller

/* File: bench/ctm_checker.sv */
// concurrent checks on the pins and status of the transceiver end
`timescale 1ns/1ps
`include "ctm_cfg.svh"
module ctm_checker
#(
    parameter int DTO_CYC = `CTM_DTO_CYC
)
(
    // clock, reset
    input wire logic       ref_clk,
    input wire logic       arst_n,
    // resolved pins, receive drive and enable
    input wire logic       txdLevel,
    input wire logic       stbLevel,
    input wire logic       shdnLevel,
    input wire logic       rxdOut,
    input wire logic       rxdOe,
    // transceiver ports
    input wire logic       busDomIn,
    input wire logic       wakePatternIn,
    input wire logic       logicIoSupplyIn,
    input wire logic       busDriveDom,
    input wire logic       busWeakGnd,
    input wire logic       dominantTimeout,
    input wire logic [1:0] modeOut
);
    logic [2:0]  upCnt;
    logic [15:0] lowCnt;
    logic        nrm;

    assign nrm = modeOut == 2'h0;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    // edges since reset, keeps $past clear of reset values
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            upCnt <= 3'h0;
        else if (upCnt != 3'h7)
            upCnt <= upCnt + 3'h1;
    end

    // dominant run length; a low txd without a fall never arms
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            lowCnt <= 16'h0;
        else if (txdLevel || !nrm)
            lowCnt <= 16'h0;
        else if ($fell(txdLevel))
            lowCnt <= 16'h1;
        else if (lowCnt != 16'h0 && lowCnt != 16'hFFFF)
            lowCnt <= lowCnt + 16'h1;
    end

    property p_shutdown_select; shdnLevel |=> modeOut == 2'h2; endproperty
    a_shutdown_select: assert property (p_shutdown_select) else $error("no shutdown");
    property p_stb; !shdnLevel && stbLevel |=> modeOut == 2'h1; endproperty
    a_stb: assert property (p_stb) else $error("no standby");
    property p_nrm; !shdnLevel && !stbLevel |=> nrm; endproperty
    a_nrm: assert property (p_nrm) else $error("no normal");
    property p_drv; busWeakGnd == !nrm && (nrm || !busDriveDom); endproperty
    a_drv: assert property (p_drv) else $error("bad drive");
    property p_txd; nrm && $fell(txdLevel) |=> busDriveDom; endproperty
    a_txd: assert property (p_txd) else $error("no dominant");
    property p_txr; nrm && txdLevel |=> !busDriveDom; endproperty
    a_txr: assert property (p_txr) else $error("no recessive");
    property p_rx;
        upCnt == 3'h7 && nrm && $past(nrm) && $past(nrm, 2)
        |-> rxdOut == !($past(busDomIn, 3) || $past(busDriveDom));
    endproperty
    a_rx: assert property (p_rx) else $error("rxd off bus");
    property p_shrx; modeOut == 2'h2 && $past(modeOut) == 2'h2 |-> rxdOut;
    endproperty
    a_shrx: assert property (p_shrx) else $error("rxd low");
    property p_wake; (modeOut == 2'h1 && wakePatternIn) [*6] |-> !rxdOut;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_dto; lowCnt == DTO_CYC + 1 |-> dominantTimeout && !busDriveDom;
    endproperty
    a_dto: assert property (p_dto) else $error("no timeout");
    property p_early;
        lowCnt != 16'h0 && lowCnt <= DTO_CYC |-> !dominantTimeout;
    endproperty
    a_early: assert property (p_early) else $error("early timeout");
    property p_clr; dominantTimeout && txdLevel |=> !dominantTimeout;
    endproperty
    a_clr: assert property (p_clr) else $error("fault stuck");
    property p_oe; upCnt == 3'h7 |-> rxdOe == $past(logicIoSupplyIn, 3);
    endproperty
    a_oe: assert property (p_oe) else $error("bad rxd enable");
endmodule : ctm_checker

/* File: bench/can_transceiver_mode_timeout_logic_tb_top.sv */
// self-checking bench joining controller and transceiver ends
`timescale 1ns/1ps
`include "ctm_cfg.svh"
module can_transceiver_mode_timeout_logic_tb_top;
    localparam int DTO_CYC = `CTM_SIM_DTO_CYC; // keeps the run brief

    logic        ref_clk;
    logic        arst_n;
    logic        ce;
    logic        tieNormal;
    logic        reqStandby;
    logic        reqShutdown;
    logic        autoWake;
    logic        txBit;
    logic [15:0] bitPeriod;
    logic        rxBit;
    logic        wakeSeen;
    logic        rateOk;
    logic        busDomIn;
    logic        wakePatternIn;
    logic        logicIoSupplyIn;
    logic        busDriveDom;
    logic        busWeakGnd;
    logic        dominantTimeout;
    logic [1:0]  modeOut;
    int          error_cnt;
    int          checks;

    ctm_if i_ctm_if ();

    ctm_controller i_ctm_controller
    (
        .ref_clk(ref_clk), .arst_n(arst_n), .ce(ce), .pins(i_ctm_if.host),
        .tieNormal(tieNormal), .reqStandby(reqStandby),
        .reqShutdown(reqShutdown), .autoWake(autoWake), .txBit(txBit),
        .bitPeriod(bitPeriod), .rxBit(rxBit), .wakeSeen(wakeSeen),
        .rateOk(rateOk)
    );

    ctm_transceiver #(.DTO_CYC(DTO_CYC)) i_ctm_transceiver
    (
        .ref_clk(ref_clk), .arst_n(arst_n), .ce(ce), .pins(i_ctm_if.dev),
        .busDomIn(busDomIn), .wakePatternIn(wakePatternIn),
        .logicIoSupplyIn(logicIoSupplyIn), .busDriveDom(busDriveDom),
        .busWeakGnd(busWeakGnd), .dominantTimeout(dominantTimeout),
        .modeOut(modeOut)
    );

    ctm_checker #(.DTO_CYC(DTO_CYC)) i_ctm_checker
    (
        .ref_clk(ref_clk), .arst_n(arst_n), .txdLevel(i_ctm_if.txdLevel),
        .stbLevel(i_ctm_if.stbLevel), .shdnLevel(i_ctm_if.shdnLevel),
        .rxdOut(i_ctm_if.rxdOut), .rxdOe(i_ctm_if.rxdOe),
        .busDomIn(busDomIn), .wakePatternIn(wakePatternIn),
        .logicIoSupplyIn(logicIoSupplyIn), .busDriveDom(busDriveDom),
        .busWeakGnd(busWeakGnd), .dominantTimeout(dominantTimeout),
        .modeOut(modeOut)
    );

    // 10 MHz reference
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic w(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : w

    task automatic chk(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_mode(input logic [1:0] got, input logic [1:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: mode %h want %h", $time, got, exp);
        end
    endtask : chk_mode

    task automatic finish_test;
        if (error_cnt == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test

    task automatic tx(input logic v);
        @(posedge ref_clk);
        txBit <= v;
    endtask : tx

    task automatic bus(input logic v);
        @(posedge ref_clk);
        busDomIn <= v;
    endtask : bus

    task automatic setm(input logic s);
        @(posedge ref_clk);
        reqStandby <= s;
        reqShutdown <= 1'b0;
        tieNormal <= 1'b0;
        w(4);
    endtask : setm

    // pin table: stb, shutdown_select, tie, expected mode
    task automatic t_modes;
        logic [4:0] tbl [5] = '{5'h11, 5'h00, 5'h1A, 5'h0A, 5'h14};
        foreach (tbl[i])
        begin
            @(posedge ref_clk);
            reqStandby <= tbl[i][4];
            reqShutdown <= tbl[i][3];
            tieNormal <= tbl[i][2];
            w(4);
            chk_mode(modeOut, tbl[i][1:0]);
            chk(busWeakGnd, tbl[i][1:0] != 2'h0);
            chk(i_ctm_if.rxdLevel, 1'b1);
        end
    endtask : t_modes

    // own echo, foreign dominance, driver off in standby
    task automatic t_txrx;
        setm(1'b0);
        tx(1'b0);
        w(6);
        chk(busDriveDom, 1'b1);
        chk(rxBit, 1'b0);
        tx(1'b1);
        bus(1'b1);
        w(6);
        chk(busDriveDom, 1'b0);
        chk(rxBit, 1'b0);
        bus(1'b0);
        w(6);
        chk(rxBit, 1'b1);
        setm(1'b1);
        tx(1'b0);
        w(4);
        chk(busDriveDom, 1'b0);
        tx(1'b1);
    endtask : t_txrx

    // stuck dominant trips, receiver stays live, recessive clears
    task automatic t_dto;
        setm(1'b0);
        tx(1'b0);
        w(DTO_CYC - 4);
        chk(dominantTimeout, 1'b0);
        w(8);
        chk(dominantTimeout, 1'b1);
        chk(busDriveDom, 1'b0);
        bus(1'b1);
        w(6);
        chk(rxBit, 1'b0);
        bus(1'b0);
        w(6);
        chk(rxBit, 1'b1);
        tx(1'b1);
        w(3);
        chk(dominantTimeout, 1'b0);
        tx(1'b0);
        w(3);
        chk(busDriveDom, 1'b1);
        tx(1'b1);
    endtask : t_dto

    // wake ignored in shutdown; wake in standby, controller brings it back
    task automatic t_wake;
        int i;
        @(posedge ref_clk);
        reqShutdown <= 1'b1;
        wakePatternIn <= 1'b1;
        w(8);
        chk(rxBit, 1'b1);
        chk(wakeSeen, 1'b0);
        @(posedge ref_clk);
        wakePatternIn <= 1'b0;
        setm(1'b1);
        // rxBit lags the mode by two edges, so look once standby shows
        w(2);
        chk(rxBit, 1'b1);
        @(posedge ref_clk);
        wakePatternIn <= 1'b1;
        w(8);
        chk(rxBit, 1'b0);
        chk(wakeSeen, 1'b1);
        @(posedge ref_clk);
        wakePatternIn <= 1'b0;
        autoWake <= 1'b1;
        for (i = 0; i < 20 && modeOut !== 2'h0; i++)
            w(1);
        chk(i < 20, 1'b1);
        if (i == 20)
            finish_test();
        @(posedge ref_clk);
        reqStandby <= 1'b0;
        autoWake <= 1'b0;
        w(4);
    endtask : t_wake

    // no logic supply: rxd floats high even with a dominant bus
    task automatic t_supply;
        bus(1'b1);
        logicIoSupplyIn <= 1'b0;
        w(6);
        chk(i_ctm_if.rxdOe, 1'b0);
        chk(rxBit, 1'b1);
        bus(1'b0);
        logicIoSupplyIn <= 1'b1;
        w(6);
        chk(i_ctm_if.rxdOe, 1'b1);
    endtask : t_supply

    // eleven bits against the timeout: edge and zero periods
    task automatic t_rate;
        logic [16:0] tbl [3] = '{17'h10442, 17'h00443, 17'h00000};
        foreach (tbl[i])
        begin
            @(posedge ref_clk);
            bitPeriod <= tbl[i][15:0];
            w(3);
            chk(rateOk, tbl[i][16]);
        end
    endtask : t_rate

    // main sequence
    initial
    begin
        error_cnt = 0;
        checks = 0;
        arst_n = 1'b0;
        ce = 1'b1;
        tieNormal = 1'b0;
        reqStandby = 1'b1;
        reqShutdown = 1'b0;
        autoWake = 1'b0;
        txBit = 1'b1;
        bitPeriod = 16'h0064;
        busDomIn = 1'b0;
        wakePatternIn = 1'b0;
        logicIoSupplyIn = 1'b1;
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_modes();
        t_txrx();
        t_dto();
        t_wake();
        t_supply();
        t_rate();
        finish_test();
    end
endmodule : can_transceiver_mode_timeout_logic_tb_top
